// file: pio_fifo_pacer.sv
/*
 Pattern I/O engine: AHB-Lite registers, 16K-word input and output FIFOs,
 internal pacer with three-counter timer, external strobe, handshake and
 burst handshake clocking, overrun and underrun status.
 Assumes hclk is the board oscillator, pins are asynchronous to it, and a
 bridge DMA engine drains/fills the FIFOs over valid/ready.
*/
`timescale 1ns/10ps
`include "pio_map.svh"
module pio_fifo_pacer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire pio_pkg::pio_ahb_req_s ahb_req,
    output pio_pkg::pio_ahb_rsp_s ahb_rsp,
    input wire pio_pkg::pio_pins_in_s pins_in,
    output pio_pkg::pio_pins_out_s pins_out,
    output logic in_dma_valid,
    input wire logic in_dma_ready,
    output logic [31:0] in_dma_data,
    input wire logic out_dma_valid,
    output logic out_dma_ready,
    input wire logic [31:0] out_dma_data,
    output logic timer_event
);
    import pio_pkg::*;

    pio_state_s s;
    pio_state_s n;
    // depth fixed in words whatever the width; each word is one sample
    logic [31:0] in_mem [0:16383]; // R05 R11
    logic [31:0] out_mem [0:16383]; // R05 R11
    logic in_push;
    logic in_pop;
    logic out_push;
    logic out_pop;
    logic [31:0] in_push_word;

    function automatic logic pio_act(input logic lvl, input logic pol);
        return lvl ^ pol; // R23
    endfunction : pio_act

    function automatic logic pio_pick(input logic [1:0] sel, input logic half, input logic quarter,
                                      input logic tmr);
        if (sel == `PIO_RATE_HALF) begin
            return half;
        end else if (sel == `PIO_RATE_QUARTER) begin
            return quarter;
        end else begin
            return tmr;
        end
    endfunction : pio_pick

    function automatic logic [31:0] pio_pack(input logic [1:0] width, input logic [15:0] a,
                                             input logic [15:0] b);
        if (width == `PIO_W8) begin
            return {24'h000000, a[7:0]}; // R03
        end else if (width == `PIO_W32) begin
            return {b, a}; // R04
        end else begin
            return {16'h0000, a};
        end
    endfunction : pio_pack

    always_comb begin
        logic tick_half;
        logic tick_quarter;
        logic in_tick;
        logic out_tick;
        logic req_lvl;
        logic req_edge;
        logic ack_lvl;
        logic in_trg_edge;
        logic out_trg_edge;
        logic wide_in;
        logic wide_out;
        logic in_run;
        logic out_run;
        logic in_full;
        logic out_empty;
        logic in_sample;
        logic out_take;
        logic [2:0] tmr_tick;
        logic [31:0] wd;
        tick_half = 1'b0;
        tick_quarter = 1'b0;
        in_tick = 1'b0;
        out_tick = 1'b0;
        req_lvl = 1'b0;
        req_edge = 1'b0;
        ack_lvl = 1'b0;
        in_trg_edge = 1'b0;
        out_trg_edge = 1'b0;
        wide_in = 1'b0;
        wide_out = 1'b0;
        in_run = 1'b0;
        out_run = 1'b0;
        in_full = 1'b0;
        out_empty = 1'b0;
        in_sample = 1'b0;
        out_take = 1'b0;
        tmr_tick = 3'h0;
        wd = ahb_req.hwdata;
        n = s;
        in_push = 1'b0;
        in_pop = 1'b0;
        out_push = 1'b0;
        out_pop = 1'b0;

        // first stage feeds only the second
        n.sync1 = pins_in;
        n.sync2 = s.sync1;
        n.prev = s.sync2;

        // pacer: half and quarter of hclk, timer counts quarter ticks
        n.div_cnt = s.div_cnt + 2'h1; // R21
        tick_half = s.div_cnt[0]; // R21
        tick_quarter = (s.div_cnt == 2'h3); // R21
        for (int i = 0; i < 3; i++) begin
            tmr_tick[i] = tick_quarter && (s.tmr_cnt[i] == 16'h0000);
            if (tick_quarter) begin
                n.tmr_cnt[i] = tmr_tick[i] ? s.tmr_reload[i] : s.tmr_cnt[i] - 16'h0001;
            end
        end
        n.tmr_evt = tmr_tick[2]; // R13
        in_tick = pio_pick(s.in_rate, tick_half, tick_quarter, tmr_tick[0]); // R12 R13
        out_tick = pio_pick(s.out_rate, tick_half, tick_quarter, tmr_tick[1]); // R12 R13

        // register writes land in the data phase
        if (s.a_valid && s.a_write) begin
            case (s.a_addr)
                `PIO_OFF_CTRL: begin
                    n.width = wd[`PIO_CTRL_WIDTH +: 2]; // R01
                    n.wide_out = wd[`PIO_CTRL_WIDE_OUT];
                    n.in_mode = pio_clk_mode_e'(wd[`PIO_CTRL_IN_MODE +: 2]);
                    n.out_mode = pio_clk_mode_e'(wd[`PIO_CTRL_OUT_MODE +: 2]);
                    n.in_rate = wd[`PIO_CTRL_IN_RATE +: 2];
                    n.out_rate = wd[`PIO_CTRL_OUT_RATE +: 2];
                    n.in_en = wd[`PIO_CTRL_IN_EN];
                    n.out_en = wd[`PIO_CTRL_OUT_EN];
                    n.in_wait = wd[`PIO_CTRL_IN_WAIT];
                    n.out_wait = wd[`PIO_CTRL_OUT_WAIT];
                    if (!s.in_en && wd[`PIO_CTRL_IN_EN]) begin
                        n.overrun = 1'b0; // R28
                    end
                    if (!s.out_en && wd[`PIO_CTRL_OUT_EN]) begin
                        n.underrun = 1'b0; // R28
                    end
                end
                `PIO_OFF_STATUS: begin
                    if (wd[`PIO_ST_OVERRUN]) begin
                        n.overrun = 1'b0; // R28
                    end
                    if (wd[`PIO_ST_UNDERRUN]) begin
                        n.underrun = 1'b0; // R28
                    end
                end
                `PIO_OFF_POL: n.pol = wd[5:0]; // R23
                `PIO_OFF_TMR0: begin
                    n.tmr_reload[0] = wd[15:0];
                    n.tmr_cnt[0] = wd[15:0];
                end
                `PIO_OFF_TMR1: begin
                    n.tmr_reload[1] = wd[15:0];
                    n.tmr_cnt[1] = wd[15:0];
                end
                `PIO_OFF_TMR2: begin
                    n.tmr_reload[2] = wd[15:0];
                    n.tmr_cnt[2] = wd[15:0];
                end
                `PIO_OFF_THR: begin
                    // first write almost-empty, second almost-full
                    if (!s.thr_phase) begin
                        n.in_ae = wd[31:16]; // R24
                        n.out_ae = wd[15:0]; // R24
                    end else begin
                        n.in_af = wd[31:16]; // R24
                        n.out_af = wd[15:0]; // R24
                    end
                    n.thr_phase = !s.thr_phase; // R24
                end
                default: begin
                end
            endcase
        end

        req_lvl = pio_act(s.sync2.input_strobe_req_line, s.pol[`PIO_POL_IN_REQ]);
        req_edge = req_lvl && !pio_act(s.prev.input_strobe_req_line, s.pol[`PIO_POL_IN_REQ]); // R14
        ack_lvl = pio_act(s.sync2.output_ack_line, s.pol[`PIO_POL_OUT_ACK]);
        in_trg_edge = pio_act(s.sync2.input_trigger_line, s.pol[`PIO_POL_IN_TRG])
            && !pio_act(s.prev.input_trigger_line, s.pol[`PIO_POL_IN_TRG]);
        out_trg_edge = pio_act(s.sync2.output_trigger_line, s.pol[`PIO_POL_OUT_TRG])
            && !pio_act(s.prev.output_trigger_line, s.pol[`PIO_POL_OUT_TRG]);
        wide_in = (s.width == `PIO_W32) && !s.wide_out;
        wide_out = (s.width == `PIO_W32) && s.wide_out;
        n.in_started = s.in_en && (s.in_started || in_trg_edge);
        n.out_started = s.out_en && (s.out_started || out_trg_edge);
        // wide mode steals the other direction's port and handshake
        in_run = s.in_en && !wide_out && (!s.in_wait || s.in_started); // R04 R25
        out_run = s.out_en && !wide_in && (!s.out_wait || s.out_started); // R04 R25
        in_full = (s.in_cnt == `PIO_FIFO_DEPTH);
        out_empty = (s.out_cnt == 15'h0000);

        // input side
        unique case (s.in_mode)
            PIO_CLK_INT: in_sample = in_run && in_tick; // R12
            PIO_CLK_EXT: in_sample = in_run && req_edge; // R14
            PIO_CLK_HS: in_sample = 1'b0;
            PIO_CLK_BURST: in_sample = in_run && in_tick && req_lvl;
        endcase
        if (s.in_mode == PIO_CLK_HS) begin
            unique case (s.in_hs)
                PIO_IN_IDLE: begin
                    if (in_run && req_lvl && !in_full) begin
                        in_sample = 1'b1; // R17
                        n.in_hs_ack = 1'b1; // R17 R26
                        n.in_hs = PIO_IN_HOLD;
                    end
                end
                PIO_IN_HOLD: begin
                    if (!req_lvl) begin
                        n.in_hs_ack = 1'b0; // R26
                        n.in_hs = PIO_IN_IDLE;
                    end
                end
            endcase
        end else begin
            n.in_hs = PIO_IN_IDLE;
            n.in_hs_ack = 1'b0;
        end
        in_push_word = pio_pack(s.width, s.sync2.first_port_in, s.sync2.second_port_in);
        if (in_sample) begin
            if (in_full) begin
                n.overrun = 1'b1; // R07 R08
            end else begin
                in_push = 1'b1;
            end
        end

        // output side
        unique case (s.out_mode)
            PIO_CLK_INT: out_take = out_run && out_tick; // R12
            PIO_CLK_EXT: out_take = 1'b0; // R14
            PIO_CLK_HS: out_take = 1'b0;
            PIO_CLK_BURST: out_take = out_run && out_tick && ack_lvl; // R19
        endcase
        if (out_take) begin
            if (out_empty) begin
                n.underrun = 1'b1; // R10
            end else begin
                out_pop = 1'b1;
            end
        end
        if (s.out_mode == PIO_CLK_HS) begin
            unique case (s.out_hs)
                PIO_OUT_IDLE: begin
                    if (out_run && !out_empty) begin
                        out_pop = 1'b1; // R27
                        n.out_hs = PIO_OUT_PRESENT;
                    end
                end
                PIO_OUT_PRESENT: begin
                    n.out_req = 1'b1; // R18 R27
                    n.out_hs = PIO_OUT_WAIT;
                end
                PIO_OUT_WAIT: begin
                    if (ack_lvl) begin
                        n.out_req = 1'b0; // R18
                        n.out_hs = PIO_OUT_DONE;
                    end
                end
                PIO_OUT_DONE: begin
                    if (!ack_lvl) begin
                        n.out_hs = PIO_OUT_IDLE;
                    end
                end
            endcase
        end else begin
            n.out_hs = PIO_OUT_IDLE;
            n.out_req = 1'b0;
        end
        // on underrun out_word is simply not reloaded, so the pins hold
        if (out_pop) begin
            n.out_word = out_mem[s.out_rd]; // R10
            n.out_rd = s.out_rd + 14'h0001;
        end
        if (wide_out) begin
            n.port_a_out = n.out_word[31:16]; // R04
            n.port_b_out = n.out_word[15:0]; // R04
        end else begin
            n.port_a_out = 16'h0000;
            n.port_b_out = (s.width == `PIO_W8) ? {8'h00, n.out_word[7:0]} : n.out_word[15:0]; // R03
        end

        // bridge side
        in_pop = (s.in_cnt != 15'h0000) && in_dma_ready; // R06
        out_push = out_dma_valid && (s.out_cnt != `PIO_FIFO_DEPTH); // R09
        if (in_push) begin
            n.in_wr = s.in_wr + 14'h0001;
        end
        if (in_pop) begin
            n.in_rd = s.in_rd + 14'h0001;
        end
        if (out_push) begin
            n.out_wr = s.out_wr + 14'h0001;
        end
        n.in_cnt = s.in_cnt + 15'(in_push) - 15'(in_pop);
        n.out_cnt = s.out_cnt + 15'(out_push) - 15'(out_pop);

        // address phase; read data taken after this cycle's updates, full and empty flags before them
        n.a_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
        if (n.a_valid) begin
            n.a_write = ahb_req.hwrite;
            n.a_addr = {ahb_req.haddr[7:2], 2'h0};
            n.hrdata = 32'h00000000;
            case (n.a_addr)
                `PIO_OFF_CTRL: n.hrdata = {16'h0000, n.out_wait, n.in_wait, n.out_en, n.in_en, n.out_rate,
                                           n.in_rate, n.out_mode, n.in_mode, 1'b0, n.wide_out, n.width};
                `PIO_OFF_STATUS: n.hrdata = {1'b0, n.in_cnt, 12'h000, out_empty, in_full,
                                             n.underrun, n.overrun}; // R08 R10
                `PIO_OFF_POL: n.hrdata = {26'h0000000, n.pol};
                `PIO_OFF_TMR0: n.hrdata = {16'h0000, n.tmr_cnt[0]};
                `PIO_OFF_TMR1: n.hrdata = {16'h0000, n.tmr_cnt[1]};
                `PIO_OFF_TMR2: n.hrdata = {16'h0000, n.tmr_cnt[2]};
                default: n.hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.width <= `PIO_W16; // R01 R02
            s.tmr_reload <= {3{`PIO_TMR_RESET}};
            s.tmr_cnt <= {3{`PIO_TMR_RESET}};
            s.in_ae <= `PIO_THR_RESET;
            s.in_af <= `PIO_THR_RESET;
            s.out_ae <= `PIO_THR_RESET;
            s.out_af <= `PIO_THR_RESET;
        end else if (clk_en) begin
            s <= n;
        end
    end

    always_ff @(posedge hclk) begin
        if (clk_en && in_push) begin
            in_mem[s.in_wr] <= in_push_word;
        end
        if (clk_en && out_push) begin
            out_mem[s.out_wr] <= out_dma_data;
        end
    end

    always_comb begin
        logic wide_in_mode;
        wide_in_mode = (s.width == `PIO_W32) && !s.wide_out;
        ahb_rsp.hreadyout = 1'b1;
        ahb_rsp.hresp = 1'b0;
        ahb_rsp.hrdata = s.hrdata;
        pins_out.first_port_out = s.port_a_out;
        pins_out.first_port_oe_n = !((s.width == `PIO_W32) && s.wide_out); // R02 R04
        pins_out.second_port_out = s.port_b_out;
        pins_out.second_port_oe_n = wide_in_mode; // R02 R04
        if (s.in_mode == PIO_CLK_EXT) begin
            pins_out.input_ack_line = pio_act(s.in_en && !((17'(s.in_cnt) + 17'(s.in_af))
                >= 17'(`PIO_FIFO_DEPTH)), s.pol[`PIO_POL_IN_ACK]); // R15
        end else begin
            pins_out.input_ack_line = pio_act(s.in_hs_ack, s.pol[`PIO_POL_IN_ACK]); // R17
        end
        pins_out.output_req_line = pio_act(s.out_req, s.pol[`PIO_POL_OUT_REQ]); // R18
        in_dma_valid = (s.in_cnt != 15'h0000) && clk_en; // R06
        in_dma_data = in_mem[s.in_rd];
        out_dma_ready = (s.out_cnt != `PIO_FIFO_DEPTH) && clk_en; // R09
        timer_event = s.tmr_evt; // R13
    end
endmodule : pio_fifo_pacer

// file: pio_map.svh
/*
 Offsets, field positions, reset values and counts of the pattern I/O FIFO pacer.
 Assumes inclusion by the design module only.
*/
// Behaviour
// R01: width 8/16/32, resets to 16
// R02: reset: first port in, second out
// R03: 8-bit width uses low byte only
// R04: 32-bit joins both ports, same direction
// R05: two 16K-word FIFOs, input and output
// R06: nonempty input FIFO requests bridge transfer
// R07: input sample dropped while FIFO full
// R08: input overrun flag readable by software
// R09: bridge writes stall while output full
// R10: underrun holds output, sets status flag
// R11: depth 16K samples at every width
// R12: pacer picks 20 MHz, 10 MHz, timer
// R13: timer 0 input, 1 output, 2 event
// R14: external strobe input only, edge latches
// R15: external mode: ack while not almost full
// R16: source pauses strobes while ack deasserted
// R17: input handshake: request in, acknowledge out
// R18: output handshake: request out, acknowledge in
// R19: burst output: pacer tick only under ack
// R20: external strobe never above 40 MHz
// R21: pacer rates half/quarter oscillator, timer quarter
// R22: descriptors carry addresses, length, next link
// R23: polarity bit per line, one=falling
// R24: thresholds: two writes, almost-empty first
// R25: wide modes use first handshake only
// R26: request held to ack, ack to release
// R27: output data stable before and during request
// R28: status flags sticky until clear or start
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
`define PIO_OFF_CTRL 8'h00
`define PIO_OFF_STATUS 8'h04
`define PIO_OFF_POL 8'h08
`define PIO_OFF_TMR0 8'h0C
`define PIO_OFF_TMR1 8'h10
`define PIO_OFF_TMR2 8'h14
`define PIO_OFF_THR 8'h18
`define PIO_CTRL_WIDTH 0
`define PIO_CTRL_WIDE_OUT 2
`define PIO_CTRL_IN_MODE 4
`define PIO_CTRL_OUT_MODE 6
`define PIO_CTRL_IN_RATE 8
`define PIO_CTRL_OUT_RATE 10
`define PIO_CTRL_IN_EN 12
`define PIO_CTRL_OUT_EN 13
`define PIO_CTRL_IN_WAIT 14
`define PIO_CTRL_OUT_WAIT 15
`define PIO_ST_OVERRUN 0
`define PIO_ST_UNDERRUN 1
`define PIO_ST_IN_COUNT 16
`define PIO_POL_IN_REQ 0
`define PIO_POL_IN_ACK 1
`define PIO_POL_IN_TRG 2
`define PIO_POL_OUT_REQ 3
`define PIO_POL_OUT_ACK 4
`define PIO_POL_OUT_TRG 5
`define PIO_W8 2'h0
`define PIO_W16 2'h1
`define PIO_W32 2'h2
`define PIO_RATE_HALF 2'h0
`define PIO_RATE_QUARTER 2'h1
`define PIO_FIFO_DEPTH 15'h4000
`define PIO_THR_RESET 16'h0008
`define PIO_TMR_RESET 16'h0004
`endif

// file: pio_pkg.sv
/*
 Types of the pattern I/O FIFO pacer: bus carriers, pin groups, modes, state.
 Assumes a single AHB-Lite master and one external peripheral.
*/
package pio_pkg;
    typedef enum logic [1:0] {PIO_CLK_INT, PIO_CLK_EXT, PIO_CLK_HS, PIO_CLK_BURST} pio_clk_mode_e;
    typedef enum logic {PIO_IN_IDLE, PIO_IN_HOLD} pio_in_hs_e;
    typedef enum logic [1:0] {PIO_OUT_IDLE, PIO_OUT_PRESENT, PIO_OUT_WAIT, PIO_OUT_DONE} pio_out_hs_e;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } pio_ahb_req_s;
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } pio_ahb_rsp_s;
    typedef struct packed {
        logic [15:0] first_port_in;
        logic [15:0] second_port_in;
        logic input_strobe_req_line;
        logic output_ack_line;
        logic input_trigger_line;
        logic output_trigger_line;
    } pio_pins_in_s;
    typedef struct packed {
        logic [15:0] first_port_out;
        logic first_port_oe_n;
        logic [15:0] second_port_out;
        logic second_port_oe_n;
        logic input_ack_line;
        logic output_req_line;
    } pio_pins_out_s;
    typedef struct packed {
        logic [1:0] width;
        logic wide_out;
        pio_clk_mode_e in_mode;
        pio_clk_mode_e out_mode;
        logic [1:0] in_rate;
        logic [1:0] out_rate;
        logic in_en;
        logic out_en;
        logic in_wait;
        logic out_wait;
        logic in_started;
        logic out_started;
        logic [5:0] pol;
        logic [2:0][15:0] tmr_reload;
        logic [2:0][15:0] tmr_cnt;
        logic tmr_evt;
        logic [1:0] div_cnt;
        logic thr_phase;
        logic [15:0] in_ae;
        logic [15:0] in_af;
        logic [15:0] out_ae;
        logic [15:0] out_af;
        logic overrun;
        logic underrun;
        logic [13:0] in_wr;
        logic [13:0] in_rd;
        logic [14:0] in_cnt;
        logic [13:0] out_wr;
        logic [13:0] out_rd;
        logic [14:0] out_cnt;
        pio_pins_in_s sync1;
        pio_pins_in_s sync2;
        pio_pins_in_s prev;
        pio_in_hs_e in_hs;
        logic in_hs_ack;
        pio_out_hs_e out_hs;
        logic out_req;
        logic [31:0] out_word;
        logic [15:0] port_a_out;
        logic [15:0] port_b_out;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
    } pio_state_s;
endpackage : pio_pkg

// file: pio_checker_assertions.sv
/*
 Port checker of pio_fifo_pacer: bus answer, pin handshakes, DMA sides.
 Assumes a bind to the top module; sees its ports only.
*/
`timescale 1ns/10ps
module pio_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire pio_pkg::pio_ahb_rsp_s ahb_rsp,
    input wire pio_pkg::pio_pins_in_s pins_in,
    input wire pio_pkg::pio_pins_out_s pins_out,
    input wire logic in_dma_valid,
    input wire logic in_dma_ready,
    input wire logic out_dma_valid,
    input wire logic out_dma_ready,
    input wire logic timer_event
);
    import pio_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_req_held;
        pins_out.output_req_line ##1 pins_out.output_req_line;
    endsequence
    property p_okay;
        ahb_rsp.hreadyout && !ahb_rsp.hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
    property p_dir;
        $rose(hresetn) |-> pins_out.first_port_oe_n && !pins_out.second_port_oe_n;
    endproperty
    a_dir: assert property (p_dir) else $error("port direction after reset");
    property p_hold;
        s_req_held |-> $stable(pins_out.second_port_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output word moved under request");
    property p_drop;
        $fell(pins_out.output_req_line) |-> $past(pins_in.output_ack_line, 2);
    endproperty
    a_drop: assert property (p_drop) else $error("request dropped without acknowledge");
    property p_valid;
        in_dma_valid && !in_dma_ready && clk_en |=> in_dma_valid || !clk_en;
    endproperty
    a_valid: assert property (p_valid) else $error("input word lost before transfer");
    property p_frozen;
        !clk_en |-> !in_dma_valid && !out_dma_ready;
    endproperty
    a_frozen: assert property (p_frozen) else $error("handshake while frozen");
    property p_stall;
        $fell(out_dma_ready) && clk_en && $past(clk_en) |-> $past(out_dma_valid);
    endproperty
    a_stall: assert property (p_stall) else $error("stall without a write");
    property p_tick;
        timer_event |=> !timer_event;
    endproperty
    a_tick: assert property (p_tick) else $error("timer event longer than a cycle");
endmodule : pio_checker

// file: pio_peer.sv
/*
 Far-side peripheral: input strobe clock and output acknowledge.
 Assumes the bench opens and closes strobe frames.
*/
`timescale 1ns/10ps
module pio_peer (
    input wire logic ext_run,
    input wire pio_pkg::pio_pins_out_s pins_out,
    output pio_pkg::pio_pins_in_s pins_in
);
    import pio_pkg::*;
    logic [15:0] word = 16'h1234;
    logic req = 1'b0;
    logic ack = 1'b0;
    logic slow = 1'b0;
    assign pins_in = '{word, ~word, req, ack, 1'b0, 1'b0};
    // strobe still between frames, edges land on falling hclk edges; data held 400 ns
    always begin
        wait (ext_run && pins_out.input_ack_line);
        #50;
        while (ext_run && pins_out.input_ack_line) begin
            #400 req = 1'b1;
            #400 req = 1'b0;
            word = word + 16'h0001;
        end
    end
    // alternates prompt and slow answers
    always begin
        wait (pins_out.output_req_line);
        #(slow ? 950 : 150) ack = 1'b1;
        wait (!pins_out.output_req_line);
        #150 ack = 1'b0;
        slow = !slow;
    end
endmodule : pio_peer

// file: pio_fifo_pacer_test.sv
/*
 Bench of pio_fifo_pacer: bus master tasks, DMA sides, scenarios.
 Assumes pio_peer on the pins and the checker bound below.
*/
`timescale 1ns/10ps
module pio_fifo_pacer_test;
    import pio_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic in_dma_ready = 1'b0, out_dma_valid = 1'b0, ext_run = 1'b0;
    logic [31:0] out_dma_data = '0;
    pio_ahb_req_s ahb_req = '{1'b1, 32'h0, 2'h0, 1'b0, 3'h2, 32'h0, 1'b1};
    pio_ahb_rsp_s ahb_rsp;
    pio_pins_in_s pins_in;
    pio_pins_out_s pins_out;
    logic in_dma_valid, out_dma_ready, timer_event;
    logic [31:0] in_dma_data;
    logic [31:0] rd;
    logic [15:0] seen[$];
    int num_errors = 0;
    int checks_done = 0;
    int n;
    always #50 hclk = ~hclk;
    pio_fifo_pacer pio_fifo_pacer_inst (.hclk, .hresetn, .clk_en, .ahb_req, .ahb_rsp, .pins_in, .pins_out,
        .in_dma_valid, .in_dma_ready, .in_dma_data, .out_dma_valid, .out_dma_ready, .out_dma_data, .timer_event);
    pio_peer pio_peer_inst (.ext_run, .pins_out, .pins_in);
    always @(posedge hclk) begin
        if (hresetn && (seen.size() == 0 || pins_out.second_port_out !== seen[$]))
            seen.push_back(pins_out.second_port_out);
    end
    task automatic stop_test;
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic sig(input int w);
        case (w)
            0: return pins_out.output_req_line;
            1: return in_dma_valid;
            2: return out_dma_ready;
            3: return timer_event;
            default: return ahb_rsp.hreadyout;
        endcase
    endfunction : sig
    task automatic wait_sig(input int w, input logic v);
        int k;
        k = 0;
        while (sig(w) !== v && k < 1000) begin
            @(posedge hclk);
            k++;
        end
        if (k == 1000) begin
            num_errors++;
            stop_test();
        end
    endtask : wait_sig
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        ahb_req.haddr <= {24'h0, a};
        ahb_req.htrans <= 2'h2;
        ahb_req.hwrite <= wr;
        @(posedge hclk);
        wait_sig(4, 1'b1);
        ahb_req.htrans <= 2'h0;
        ahb_req.hwdata <= d;
        @(posedge hclk);
        wait_sig(4, 1'b1);
        rd = ahb_rsp.hrdata;
    endtask : bus
    task automatic reg_chk(input string what, input logic [7:0] a, input logic [31:0] m, exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd & m);
    endtask : reg_chk
    // valid stays up between pushes; caller lowers it
    task automatic push(input logic [31:0] d);
        out_dma_data <= d;
        out_dma_valid <= 1'b1;
        @(posedge hclk);
        wait_sig(2, 1'b1);
    endtask : push
    task automatic pop(input string what, input logic [31:0] exp);
        in_dma_ready <= 1'b1;
        @(posedge hclk);
        wait_sig(1, 1'b1);
        check(what, exp, in_dma_data);
    endtask : pop
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        reg_chk("width", 8'h00, 32'h3, 32'h1);
        for (int i = 0; i < 3; i++) push(32'hA5C0 + i);
        out_dma_valid <= 1'b0;
        bus(1'b1, 8'h00, 32'h2001);
        repeat (40) @(posedge hclk);
        check("words", 32'h4, seen.size());
        for (int i = 1; i < 4; i++) check("word", 32'hA5BF + i, seen[i]);
        reg_chk("under", 8'h04, 32'h2, 32'h2);
        bus(1'b1, 8'h00, 32'h0001);
        bus(1'b1, 8'h04, 32'h2);
        reg_chk("under", 8'h04, 32'h2, 32'h0);
        push(32'h5A01);
        push(32'h5A02);
        out_dma_valid <= 1'b0;
        bus(1'b1, 8'h00, 32'h2081);
        for (int i = 1; i < 3; i++) begin
            wait_sig(0, 1'b1);
            check("hs word", 32'h5A00 + i, pins_out.second_port_out);
            wait_sig(0, 1'b0);
        end
        bus(1'b1, 8'h18, 32'h00020002);
        bus(1'b1, 8'h18, 32'h3FFE0008);
        bus(1'b1, 8'h00, 32'h1010);
        ext_run <= 1'b1;
        repeat (6) @(posedge hclk);
        check("ack", 32'h1, pins_out.input_ack_line);
        repeat (20) @(posedge hclk);
        check("ack full", 32'h0, pins_out.input_ack_line);
        for (int i = 0; i < 4; i++) pop("byte", 32'h34 + i);
        ext_run <= 1'b0;
        bus(1'b1, 8'h00, 32'h1001);
        in_dma_ready <= 1'b0;
        // 16K samples at half rate, then one more to overrun
        repeat (32900) @(posedge hclk);
        reg_chk("over", 8'h04, 32'h7FFF0001, 32'h40000001);
        clk_en <= 1'b0;
        @(posedge hclk);
        check("frozen", 32'h0, {in_dma_valid, out_dma_ready});
        clk_en <= 1'b1;
        @(posedge hclk);
        check("valid", 32'h1, in_dma_valid);
        n = 0;
        out_dma_valid <= 1'b1;
        @(posedge hclk);
        while (out_dma_ready === 1'b1 && n < 16400) begin
            n++;
            @(posedge hclk);
        end
        out_dma_valid <= 1'b0;
        check("depth", 32'h4000, n);
        repeat (3) @(posedge hclk);
        check("stall", 32'h0, out_dma_ready);
        bus(1'b1, 8'h00, 32'h3001);
        wait_sig(2, 1'b1);
        bus(1'b1, 8'h14, 32'h0);
        wait_sig(3, 1'b1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("dir", 32'h2, {pins_out.first_port_oe_n, pins_out.second_port_oe_n});
        stop_test();
    end
endmodule : pio_fifo_pacer_test
bind pio_fifo_pacer pio_checker pio_checker_inst (.hclk, .hresetn, .clk_en, .ahb_rsp, .pins_in, .pins_out,
    .in_dma_valid, .in_dma_ready, .out_dma_valid, .out_dma_ready, .timer_event);
